/* src/rsa_pkg.sv */
// package for the rail strobe assignment registers and their sequencer
`default_nettype none

package rsa_pkg;

    // ************
    // register subaddresses and values after reset
    // ************
    localparam logic [7:0] ADDR_BB_B3     = 8'h23;   // buck-boost / buck three
    localparam logic [7:0] ADDR_BACKUP    = 8'h24;   // backup rails
    localparam logic [7:0] ADDR_SW_LDO    = 8'h25;   // load switch / linear reg
    localparam logic [7:0] ADDR_GPO       = 8'h26;   // general-purpose outputs
    localparam logic [7:0] RST_BB_B3      = 8'h84;
    localparam logic [7:0] RST_BACKUP     = 8'h10;
    localparam logic [7:0] RST_SW_LDO     = 8'h88;
    localparam logic [7:0] RST_GPO        = 8'h08;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;   // answer to other addresses

    // ************
    // field positions
    // ************
    localparam int HI_LSB  = 4;                      // upper nibble field
    localparam int LO_LSB  = 0;                      // lower nibble field
    localparam int B18_LSB = 4;                      // 1.8 V backup, bits 5..4
    localparam int B10_LSB = 0;                      // 1.0 V backup, bits 1..0

    // ************
    // strobe codes
    // ************
    localparam logic [3:0] CODE_FIRST   = 4'h3;      // lowest controlling code
    localparam logic [3:0] CODE_LAST    = 4'hA;      // highest controlling code
    localparam logic [1:0] BK_CODE_S1   = 2'h1;      // backup: strobe one
    localparam logic [1:0] BK_CODE_S2   = 2'h2;      // backup: strobe two
    localparam logic [3:0] STROBE_ONE   = 4'h1;
    localparam logic [3:0] STROBE_TWO   = 4'h2;
    localparam logic [3:0] STROBE_THREE = 4'h3;
    localparam logic [3:0] STROBE_LAST  = 4'hA;
    localparam logic [3:0] STROBE_NONE  = 4'h0;      // idle strobe number

    // ************
    // rail indices
    // ************
    localparam int NUM_RAILS   = 8;
    localparam int RAIL_BUCK3  = 0;                  // step_down_rail_three
    localparam int RAIL_BB     = 1;                  // buck_boost_rail
    localparam int RAIL_BK10   = 2;                  // backup_rail_1v0
    localparam int RAIL_BK18   = 3;                  // backup_rail_1v8
    localparam int RAIL_LDO    = 4;                  // linear_regulator_rail
    localparam int RAIL_LS     = 5;                  // low_voltage_load_switch
    localparam int RAIL_GPO1   = 6;
    localparam int RAIL_GPO3   = 7;
    localparam logic [NUM_RAILS-1:0] RAIL_EN_RST = 8'h00;

    // ************
    // timing
    // ************
    localparam int CLK_KHZ      = 200000;            // mclk rate
    localparam int DLY_SHORT_MS = 2;
    localparam int DLY_LONG_MS  = 5;
    localparam int DOWN_FACTOR  = 10;                // power-down multiplier
    localparam int CNT_W        = 24;
    localparam logic [CNT_W-1:0] SHORT_CYC    = CNT_W'(DLY_SHORT_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] LONG_CYC     = CNT_W'(DLY_LONG_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] SHORT_DN_CYC = CNT_W'(DLY_SHORT_MS * CLK_KHZ * DOWN_FACTOR);
    localparam logic [CNT_W-1:0] LONG_DN_CYC  = CNT_W'(DLY_LONG_MS * CLK_KHZ * DOWN_FACTOR);
    localparam logic [CNT_W-1:0] CNT_ONE      = 24'h00_0001;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 24'h00_0000;

    // ************
    // types
    // ************
    typedef struct packed {
        logic       wr;                              // write strobe
        logic       rd;                              // read strobe
        logic [7:0] addr;                            // subaddress
        logic [7:0] wdata;                           // write data
    } rsa_reg_req_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STROBE,
        ST_WAIT
    } rsa_state_e;

endpackage

`default_nettype wire

/* src/rsa_strobe_match.sv */
// one rail's strobe match: does the assignment code select this strobe
`default_nettype none

module rsa_strobe_match #(
    parameter bit WIDE = 1'b1                        // 4-bit field when set
) (
    // assignment and current strobe
    input  wire logic [3:0] code,
    input  wire logic [3:0] strobe,
    // result
    output logic            hit
);

    // ************
    // code decode
    // ************
    logic wide_ok;                                   // code 3..A controls
    logic narrow_ok;                                 // code bits 1..0 equal 1 or 2

    assign wide_ok   = (code >= rsa_pkg::CODE_FIRST) && (code <= rsa_pkg::CODE_LAST);
    assign narrow_ok = (code[1:0] == rsa_pkg::BK_CODE_S1) || (code[1:0] == rsa_pkg::BK_CODE_S2);
    // other codes never match any strobe
    assign hit = (WIDE ? wide_ok : narrow_ok) && (code == strobe);

endmodule

`default_nettype wire

/* src/rsa_top.sv */
// rail strobe assignment registers with the strobe sequencer that uses them
//
// Contract
// - 4-bit codes 3..A enable at that strobe
// - codes 0-2 and B-F leave rail uncontrolled
// - 0x23 holds buck-boost 7:4=8, buck3 3:0=4
// - backup register at 0x24, reset 0x10
// - backup code 1/2 strobes one/two, else none
// - 1.8V backup bits 5:4, 1.0V bits 1:0
// - strobes one and two only when seal zero
// - set seal: backup rails never disabled
// - backup bits 7:6, 3:2 read zero
// - switch/linear register at 0x25, reset 0x88
// - load switch 7:4, linear 3:0, both 8
// - general-purpose output register 0x26, reset 0x08
// - buck-boost/buck3 register 0x23, reset 0x84
// - gap delay 2 ms or 5 ms per bit
// - power-down delays times ten when selected
`default_nettype none

module rsa_top #(
    parameter logic [23:0] SHORT_CYC    = rsa_pkg::SHORT_CYC,
    parameter logic [23:0] LONG_CYC     = rsa_pkg::LONG_CYC,
    parameter logic [23:0] SHORT_DN_CYC = rsa_pkg::SHORT_DN_CYC,
    parameter logic [23:0] LONG_DN_CYC  = rsa_pkg::LONG_DN_CYC
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      sys_rst,
    // register port from the serial interface
    input  wire rsa_pkg::rsa_reg_req_s     reg_req,
    input  wire logic                      pw_unlocked,
    output logic [7:0]                     reg_rdata,
    output logic                           reg_rvalid,
    // sequencer control
    input  wire logic                      power_up_req,
    input  wire logic                      power_down_req,
    input  wire logic [8:0]                gap_long_sel,
    input  wire logic                      powerdown_delay_multiplier,
    input  wire logic                      freshness_seal_flag,
    // rail enables and status
    output logic [rsa_pkg::NUM_RAILS-1:0]  rail_en,
    output logic [3:0]                     strobe_num,
    output logic                           seq_busy
);

    // ************
    // register storage
    // ************
    // one nibble or pair per rail
    logic [3:0] buckboost_strobe_code;               // 0x23 upper
    logic [3:0] buck3_strobe_code;                   // 0x23 lower
    logic [1:0] backup_1v8_strobe_code;              // 0x24 bits 5..4
    logic [1:0] backup_1v0_strobe_code;              // 0x24 bits 1..0
    logic [3:0] low_volt_switch_strobe_code;         // 0x25 upper
    logic [3:0] linear_reg_strobe_code;              // 0x25 lower
    logic [3:0] gpo3_strobe_code;                    // 0x26 upper
    logic [3:0] gpo1_strobe_code;                    // 0x26 lower

    // ************
    // address decode
    // ************
    // one select per mapped subaddress
    logic sel_bb_b3;
    logic sel_backup;
    logic sel_sw_ldo;
    logic sel_gpo;
    logic wr_ok;                                     // write allowed

    assign sel_bb_b3  = (reg_req.addr == rsa_pkg::ADDR_BB_B3);
    assign sel_backup = (reg_req.addr == rsa_pkg::ADDR_BACKUP);
    assign sel_sw_ldo = (reg_req.addr == rsa_pkg::ADDR_SW_LDO);
    assign sel_gpo    = (reg_req.addr == rsa_pkg::ADDR_GPO);
    // locked writes are dropped silently
    assign wr_ok      = reg_req.wr && pw_unlocked;

    // ************
    // register writes
    // ************
    // writes land at the edge that takes them
    // buck-boost and buck three fields
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            buckboost_strobe_code <= rsa_pkg::RST_BB_B3[7:4];
            buck3_strobe_code     <= rsa_pkg::RST_BB_B3[3:0];
        end else if (wr_ok && sel_bb_b3) begin
            buckboost_strobe_code <= reg_req.wdata[rsa_pkg::HI_LSB +: 4];
            buck3_strobe_code     <= reg_req.wdata[rsa_pkg::LO_LSB +: 4];
        end
    end

    // backup fields; reserved bits are not stored
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            backup_1v8_strobe_code <= rsa_pkg::RST_BACKUP[5:4];
            backup_1v0_strobe_code <= rsa_pkg::RST_BACKUP[1:0];
        end else if (wr_ok && sel_backup) begin
            backup_1v8_strobe_code <= reg_req.wdata[rsa_pkg::B18_LSB +: 2];
            backup_1v0_strobe_code <= reg_req.wdata[rsa_pkg::B10_LSB +: 2];
        end
    end

    // load switch and linear regulator fields
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            low_volt_switch_strobe_code <= rsa_pkg::RST_SW_LDO[7:4];
            linear_reg_strobe_code      <= rsa_pkg::RST_SW_LDO[3:0];
        end else if (wr_ok && sel_sw_ldo) begin
            low_volt_switch_strobe_code <= reg_req.wdata[rsa_pkg::HI_LSB +: 4];
            linear_reg_strobe_code      <= reg_req.wdata[rsa_pkg::LO_LSB +: 4];
        end
    end

    // general-purpose output fields
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gpo3_strobe_code <= rsa_pkg::RST_GPO[7:4];
            gpo1_strobe_code <= rsa_pkg::RST_GPO[3:0];
        end else if (wr_ok && sel_gpo) begin
            gpo3_strobe_code <= reg_req.wdata[rsa_pkg::HI_LSB +: 4];
            gpo1_strobe_code <= reg_req.wdata[rsa_pkg::LO_LSB +: 4];
        end
    end

    // ************
    // read path
    // ************
    // answer one cycle after the read strobe
    logic [7:0] next_rdata;                          // read mux

    // reserved backup bits are driven as zero
    assign next_rdata = sel_bb_b3  ? {buckboost_strobe_code, buck3_strobe_code} :
                        sel_backup ? {2'h0, backup_1v8_strobe_code,
                                      2'h0, backup_1v0_strobe_code} :
                        sel_sw_ldo ? {low_volt_switch_strobe_code, linear_reg_strobe_code} :
                        sel_gpo    ? {gpo3_strobe_code, gpo1_strobe_code} :
                                     rsa_pkg::RDATA_UNMAPPED;

    // read data registered one cycle after the strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata  <= rsa_pkg::RDATA_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_req.rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_req.rd;
        end
    end

    // ************
    // per-rail strobe match
    // ************
    // backup codes zero-extended to four bits
    logic [3:0]                    rail_code [rsa_pkg::NUM_RAILS];
    logic [rsa_pkg::NUM_RAILS-1:0] rail_hit;         // rail selects this strobe

    assign rail_code[rsa_pkg::RAIL_BUCK3] = buck3_strobe_code;
    assign rail_code[rsa_pkg::RAIL_BB]    = buckboost_strobe_code;
    assign rail_code[rsa_pkg::RAIL_BK10]  = {2'h0, backup_1v0_strobe_code};
    assign rail_code[rsa_pkg::RAIL_BK18]  = {2'h0, backup_1v8_strobe_code};
    assign rail_code[rsa_pkg::RAIL_LDO]   = linear_reg_strobe_code;
    assign rail_code[rsa_pkg::RAIL_LS]    = low_volt_switch_strobe_code;
    assign rail_code[rsa_pkg::RAIL_GPO1]  = gpo1_strobe_code;
    assign rail_code[rsa_pkg::RAIL_GPO3]  = gpo3_strobe_code;

    // backup rails decode 2-bit codes, all others 4-bit codes
    for (genvar i = 0; i < rsa_pkg::NUM_RAILS; i++) begin : g_match
        localparam bit IS_WIDE = (i != rsa_pkg::RAIL_BK10) && (i != rsa_pkg::RAIL_BK18);
        rsa_strobe_match #(
            .WIDE   (IS_WIDE)
        ) u_match (
            .code   (rail_code[i]),
            .strobe (strobe_num),
            .hit    (rail_hit[i])
        );
    end

    // ************
    // sequencer decode
    // ************
    // starts are taken only when idle
    rsa_pkg::rsa_state_e state;
    rsa_pkg::rsa_state_e next_state;
    logic                dir_up;                     // 1 power-up, 0 power-down
    logic [23:0]         dly_left;                   // gap countdown
    logic                up_done;
    logic                down_done;
    logic                seq_last;                   // final strobe of the walk
    logic [3:0]          gap_idx;                    // gap select index
    logic                gap_long;
    logic [23:0]         gap_cycles;
    logic                start_up;
    logic                start_down;
    logic [3:0]          first_up;
    logic [3:0]          next_strobe_step;
    logic                keep_backup;                // backup stays on
    logic [rsa_pkg::NUM_RAILS-1:0] down_mask;        // rails allowed to turn off

    assign start_up   = (state == rsa_pkg::ST_IDLE) && power_up_req;
    assign start_down = (state == rsa_pkg::ST_IDLE) && power_down_req && !power_up_req;
    // a set seal skips the two backup strobes
    assign first_up   = freshness_seal_flag ? rsa_pkg::STROBE_THREE
                                            : rsa_pkg::STROBE_ONE;
    assign up_done    = dir_up && (strobe_num == rsa_pkg::STROBE_LAST);
    assign down_done  = !dir_up && ((strobe_num == rsa_pkg::STROBE_ONE) ||
                        (freshness_seal_flag && (strobe_num == rsa_pkg::STROBE_THREE)));
    assign seq_last   = up_done || down_done;
    // gap k sits between strobes k and k+1, bit k-1 selects it
    assign gap_idx    = dir_up ? (strobe_num - rsa_pkg::STROBE_ONE)
                               : (strobe_num - rsa_pkg::STROBE_TWO);
    assign gap_long   = gap_long_sel[gap_idx];
    assign gap_cycles = dir_up ? (gap_long ? LONG_CYC : SHORT_CYC)
                      : powerdown_delay_multiplier ? (gap_long ? LONG_DN_CYC
                                                               : SHORT_DN_CYC)
                      : (gap_long ? LONG_CYC : SHORT_CYC);
    assign next_strobe_step = dir_up ? (strobe_num + rsa_pkg::STROBE_ONE)
                                     : (strobe_num - rsa_pkg::STROBE_ONE);
    assign keep_backup = freshness_seal_flag;
    assign down_mask   = keep_backup ? ~((8'h01 << rsa_pkg::RAIL_BK10) |
                                         (8'h01 << rsa_pkg::RAIL_BK18))
                                     : 8'hFF;

    // state transition
    always_comb begin
        next_state = state;
        unique case (state)
            // idle until a start request
            rsa_pkg::ST_IDLE: begin
                if (start_up || start_down) begin
                    next_state = rsa_pkg::ST_STROBE;
                end
            end
            // one strobe cycle, then gap or done
            rsa_pkg::ST_STROBE: begin
                next_state = seq_last ? rsa_pkg::ST_IDLE : rsa_pkg::ST_WAIT;
            end
            // count the gap down
            rsa_pkg::ST_WAIT: begin
                if (dly_left == rsa_pkg::CNT_ONE) begin
                    next_state = rsa_pkg::ST_STROBE;
                end
            end
        endcase
    end

    // ************
    // sequencer registers
    // ************
    // each step is one edge of the walk
    // state, direction and busy flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= rsa_pkg::ST_IDLE;
            dir_up   <= 1'b1;
            seq_busy <= 1'b0;
        end else begin
            state    <= next_state;
            dir_up   <= start_up ? 1'b1 : start_down ? 1'b0 : dir_up;
            seq_busy <= (next_state != rsa_pkg::ST_IDLE);
        end
    end

    // strobe number: set at start, stepped when the gap expires
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            strobe_num <= rsa_pkg::STROBE_NONE;
        end else if (start_up) begin
            strobe_num <= first_up;
        end else if (start_down) begin
            strobe_num <= rsa_pkg::STROBE_LAST;
        end else if (state == rsa_pkg::ST_STROBE && seq_last) begin
            strobe_num <= rsa_pkg::STROBE_NONE;
        end else if (state == rsa_pkg::ST_WAIT && dly_left == rsa_pkg::CNT_ONE) begin
            strobe_num <= next_strobe_step;
        end
    end

    // gap countdown loaded at each strobe except the last
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dly_left <= rsa_pkg::CNT_ZERO;
        end else if (state == rsa_pkg::ST_STROBE && !seq_last) begin
            dly_left <= gap_cycles;
        end else if (state == rsa_pkg::ST_WAIT) begin
            dly_left <= dly_left - rsa_pkg::CNT_ONE;
        end
    end

    // rails switched in the strobe cycle: on going up, off going down
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rail_en <= rsa_pkg::RAIL_EN_RST;
        end else if (state == rsa_pkg::ST_STROBE && dir_up) begin
            rail_en <= rail_en | rail_hit;
        end else if (state == rsa_pkg::ST_STROBE) begin
            rail_en <= rail_en & ~(rail_hit & down_mask);
        end
    end

endmodule

`default_nettype wire

/* verif/rsa_checker.sv */
// assertions on the ports of the strobe assignment block
`default_nettype none
module rsa_checker #(
    parameter logic [23:0] SHORT_CYC    = 24'h00_0004,  // gap lengths as in the top
    parameter logic [23:0] LONG_CYC     = 24'h00_0007,
    parameter logic [23:0] SHORT_DN_CYC = 24'h00_0028,
    parameter logic [23:0] LONG_DN_CYC  = 24'h00_0046
) (
    // clock, reset and register port
    input  wire logic                  mclk, sys_rst, pw_unlocked, reg_rvalid,
    input  wire rsa_pkg::rsa_reg_req_s reg_req,
    input  wire logic [7:0]            reg_rdata, rail_en,
    // sequencer
    input  wire logic                  power_up_req, power_down_req, seq_busy,
    input  wire logic                  powerdown_delay_multiplier, freshness_seal_flag,
    input  wire logic [8:0]            gap_long_sel,
    input  wire logic [3:0]            strobe_num
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // helper: edges the last strobe number stood
    // ************
    logic [3:0]  prev_s;                               // number at last edge
    logic [23:0] run_len;                              // edges it stood
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_s  <= 4'h0;
            run_len <= 24'h00_0000;
        end else begin
            prev_s  <= strobe_num;
            run_len <= (strobe_num != prev_s) ? 24'h00_0001 : run_len + 24'h00_0001;
        end
    end
    wire        up_step = prev_s != 4'h0 && strobe_num == prev_s + 4'h1;
    wire        dn_step = strobe_num != 4'h0 && strobe_num + 4'h1 == prev_s;
    wire        up_long = gap_long_sel[prev_s - 4'h1];
    wire        dn_long = gap_long_sel[prev_s - 4'h2];
    wire [23:0] up_len  = (up_long ? LONG_CYC : SHORT_CYC) + 24'h00_0001;
    wire [23:0] dn_len  = (powerdown_delay_multiplier ? (dn_long ? LONG_DN_CYC : SHORT_DN_CYC)
                          : (dn_long ? LONG_CYC : SHORT_CYC)) + 24'h00_0001;
    // ************
    // properties
    // ************
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_up_go; !seq_busy && power_up_req; endsequence
    sequence s_dn_go; !seq_busy && power_down_req && !power_up_req; endsequence
    property p_up_first;
        s_up_go |=> seq_busy && strobe_num == (freshness_seal_flag ? 4'h3 : 4'h1);
    endproperty
    property p_dn_first; s_dn_go |=> seq_busy && strobe_num == 4'hA; endproperty
    property p_seal_floor;
        seq_busy && freshness_seal_flag && $past(freshness_seal_flag) |-> strobe_num >= 4'h3;
    endproperty
    property p_backup_keep;
        freshness_seal_flag && !$past(sys_rst) |-> !$fell(rail_en[2]) && !$fell(rail_en[3]);
    endproperty
    property p_up_gap; up_step |-> run_len == up_len; endproperty
    property p_dn_gap; dn_step |-> run_len == dn_len; endproperty
    property p_resv;
        reg_req.rd && reg_req.addr == rsa_pkg::ADDR_BACKUP
            |=> reg_rvalid && reg_rdata[7:6] == 2'b00 && reg_rdata[3:2] == 2'b00;
    endproperty
    property p_last; strobe_num == 4'hA && prev_s == 4'h9 |=> !seq_busy && strobe_num == 4'h0;
    endproperty
    a_up_first: assert property (p_up_first) else $error("wrong first strobe");
    a_dn_first: assert property (p_dn_first) else $error("down not from ten");
    a_seal_floor: assert property (p_seal_floor) else $error("strobe one or two ran");
    a_backup_keep: assert property (p_backup_keep) else $error("backup rail off");
    a_up_gap: assert property (p_up_gap) else $error("power-up gap length");
    a_dn_gap: assert property (p_dn_gap) else $error("power-down gap length");
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    a_last: assert property (p_last) else $error("no idle after strobe ten");
endmodule
bind rsa_top rsa_checker #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC),
    .SHORT_DN_CYC(SHORT_DN_CYC), .LONG_DN_CYC(LONG_DN_CYC)) u_chk (.mclk, .sys_rst,
    .pw_unlocked, .reg_rvalid, .reg_req, .reg_rdata, .rail_en, .power_up_req, .power_down_req,
    .seq_busy, .powerdown_delay_multiplier, .freshness_seal_flag, .gap_long_sel, .strobe_num);
`default_nettype wire

/* verif/rsa_host.sv */
// host model: single-byte accesses on the subaddress port
`default_nettype none
module rsa_host (
    // clock, request side, answer side
    input  wire logic                 mclk,
    output var rsa_pkg::rsa_reg_req_s reg_req,
    output logic                      pw_unlocked,
    input  wire logic [7:0]           reg_rdata,
    input  wire logic                 reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_req = '0;
        pw_unlocked = 1'b0;
    end
    // unlock step done or withdrawn
    task automatic unlock(input logic on);
        @(negedge mclk);
        pw_unlocked = on;
    endtask
    // held over one taking edge, answer taken in the next cycle, then released
    task automatic access(input logic wr, input logic [7:0] a, wd,
                          output logic [7:0] d, output logic ok);
        @(negedge mclk);
        reg_req = '{wr: wr, rd: !wr, addr: a, wdata: wd};
        @(negedge mclk);
        d = reg_rdata;
        ok = reg_rvalid;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~wd};
    endtask
endmodule
`default_nettype wire

/* verif/rsa_top_bench.sv */
// self-checking bench for the strobe assignment block
`default_nettype none
module rsa_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  mclk = 1'b0, sys_rst, pw_unlocked, reg_rvalid, seq_busy;
    logic                  power_up_req, power_down_req;
    logic                  powerdown_delay_multiplier, freshness_seal_flag;
    rsa_pkg::rsa_reg_req_s reg_req;
    logic [7:0]            reg_rdata, rail_en, exp_rail, d;
    logic [8:0]            gap_long_sel;
    logic [3:0]            strobe_num;
    logic [7:0]            sh [5];                    // register shadow 0x23..0x27
    logic [31:0]           state = 32'hb447_b689, r;  // random state
    int                    mismatches = 0, n_compared = 0, cycles = 0;
    rsa_top #(.SHORT_CYC(24'h00_0004), .LONG_CYC(24'h00_0007), .SHORT_DN_CYC(24'h00_0028),
        .LONG_DN_CYC(24'h00_0046)) DUT (.mclk, .sys_rst, .reg_req, .pw_unlocked, .reg_rdata,
        .reg_rvalid, .power_up_req, .power_down_req, .gap_long_sel, .powerdown_delay_multiplier,
        .freshness_seal_flag, .rail_en, .strobe_num, .seq_busy);
    rsa_host host (.mclk, .reg_req, .pw_unlocked, .reg_rdata, .reg_rvalid);
    always #2.5 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    function automatic logic [31:0] rnd();
        state ^= state << 13;
        state ^= state >> 17;
        state ^= state << 5;
        return state;
    endfunction
    // 4-bit code hits strobe k only inside 3..A
    function automatic logic w_hit(input logic [3:0] c, k);
        return c == k && c >= 4'h3 && c <= 4'hA;
    endfunction
    // rails switched at strobe k, bit order of rail_en
    function automatic logic [7:0] on_at(input logic [3:0] k);
        return {w_hit(sh[3][7:4], k), w_hit(sh[3][3:0], k), w_hit(sh[2][7:4], k),
                w_hit(sh[2][3:0], k), {2'b00, sh[1][5:4]} == k && k <= 4'h2,
                {2'b00, sh[1][1:0]} == k && k <= 4'h2, w_hit(sh[0][7:4], k), w_hit(sh[0][3:0], k)};
    endfunction
    task automatic check(input logic [7:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, exp);
        logic [7:0] v;
        logic       ok;
        host.access(1'b0, a, 8'h00, v, ok);
        check({7'h00, ok}, 8'h01, "read valid");
        check(v, exp, "read data");
    endtask
    // one sequencer run, rail enables compared every cycle
    task automatic run(input logic up);
        logic [3:0] last, want;
        last = 4'h0;
        @(negedge mclk);
        if (up) power_up_req = 1'b1;
        else power_down_req = 1'b1;
        for (int n = 0; n < 1000 && (n == 0 || seq_busy === 1'b1); n++) begin
            @(negedge mclk);
            power_up_req = 1'b0;
            power_down_req = up && n == 3;
            check(rail_en, exp_rail, "rail enables");
            if (strobe_num !== last && strobe_num !== 4'h0) begin
                want = last == 4'h0 ? (up ? (freshness_seal_flag ? 4'h3 : 4'h1) : 4'hA)
                       : (up ? last + 4'h1 : last - 4'h1);
                check({4'h0, strobe_num}, {4'h0, want}, "strobe order");
                last = strobe_num;
                exp_rail = up ? exp_rail | on_at(last)
                           : exp_rail & ~(on_at(last) & (freshness_seal_flag ? 8'hF3 : 8'hFF));
            end
        end
        check({4'h0, last}, up ? 8'h0A : (freshness_seal_flag ? 8'h03 : 8'h01), "end");
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {sys_rst, power_up_req, power_down_req, powerdown_delay_multiplier} = 4'b1000;
        {freshness_seal_flag, gap_long_sel, exp_rail} = '0;
        sh = '{8'h84, 8'h10, 8'h88, 8'h08, 8'h00};
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(8'h23 + 8'(i), sh[i]);
        host.access(1'b1, 8'h25, 8'h3A, d, r[0]);
        rd_chk(8'h25, 8'h88);
        host.unlock(1'b1);
        for (int it = 0; it < 8; it++) begin
            for (int i = 0; i < 5; i++) begin
                r = rnd();
                d = it == 0 ? 8'hFF - 8'(i * 8'h5A) : r[7:0];
                host.access(1'b1, 8'h23 + 8'(i), d, r[7:0], r[8]);
                sh[i] = d & (i == 1 ? 8'h33 : (i == 4 ? 8'h00 : 8'hFF));
                rd_chk(8'h23 + 8'(i), sh[i]);
            end
            r = rnd();
            {freshness_seal_flag, powerdown_delay_multiplier, gap_long_sel} = r[10:0];
            run(1'b1);
            freshness_seal_flag = r[11];
            run(1'b0);
        end
        freshness_seal_flag = 1'b0;
        run(1'b1);
        sys_rst = 1'b1;
        @(negedge mclk);
        check(rail_en, 8'h00, "rails in reset");
        sys_rst = 1'b0;
        rd_chk(8'h24, 8'h10);
        final_report();
    end
endmodule
`default_nettype wire
